// *** hdl/rtcu_top.sv ***
// Rotate-through-carry execution unit: decode, sequencing, flags
`timescale 1ns/1ps
module rtcu_top
	import rtcu_pkg::*;
(
	input  wire logic      clk,
	input  wire logic      nrst,
	input  wire logic      start,
	input  wire rtcu_req_t req,
	output logic           busy,
	output logic           done,
	output rtcu_rsp_t      rsp
);

	typedef enum logic [1:0] {
		RTCU_IDLE = 2'b00,
		RTCU_RUN  = 2'b01
	} rtcu_state_t;

	rtcu_state_t state_ff;
	logic [15:0] val_ff;
	logic        cy_ff;
	logic        of_ff;
	logic        word_ff;
	logic        right_ff;
	logic        mem_ff;
	logic [4:0]  steps_ff;
	logic [4:0]  cnt_ff;
	logic [5:0]  wait_ff;
	logic        illegal_ff;
	logic        done_ff;
	rtcu_rsp_t   rsp_ff;

	logic        dec_ok;
	logic        dec_word;
	logic        dec_right;
	logic [4:0]  dec_cnt;
	logic [5:0]  dec_wait;
	logic [15:0] step_val;
	logic        step_cy;
	logic [15:0] op_in;
	logic        fin_now;
	logic        of_new;

	// Decode opcode and reg field to size, direction and count
	always_comb begin
		dec_ok    = 1'b1;
		dec_word  = req.opcode[0];
		dec_right = (req.ext == RTCU_EXT_RIGHT);
		dec_cnt   = 5'd1;
		case (req.opcode)
			RTCU_OP_ONE_B, RTCU_OP_ONE_W: dec_cnt = 5'd1;
			RTCU_OP_CNT_B, RTCU_OP_CNT_W: dec_cnt = req.count_register_low[RTCU_CNT_BITS-1:0];
			RTCU_OP_IMM_B, RTCU_OP_IMM_W: dec_cnt = req.immediate_count_byte[RTCU_CNT_BITS-1:0];
			default:                      dec_ok = 1'b0;
		endcase
		if (req.ext != RTCU_EXT_LEFT && req.ext != RTCU_EXT_RIGHT) begin
			dec_ok = 1'b0;
		end
	end

	// Total clocks minus the rotate steps and the finishing cycle
	always_comb begin
		if (req.opcode == RTCU_OP_ONE_B || req.opcode == RTCU_OP_ONE_W) begin
			dec_wait = req.is_mem ? 6'(RTCU_CLK_ONE_MEM - 2) : 6'(RTCU_CLK_ONE_REG - 2);
		end else begin
			dec_wait = req.is_mem ? 6'(RTCU_CLK_VAR_MEM - 1) : 6'(RTCU_CLK_VAR_REG - 1);
		end
	end

	// Byte operands only carry the low byte into the ring
	assign op_in = dec_word ? req.operand : {8'h00, req.operand[7:0]};

	// Last clock of an instruction: every step and slot spent, result goes out here
	assign fin_now = (state_ff == RTCU_RUN) && (steps_ff == 5'd0) && (wait_ff == 6'd0);

	rtcu_step u_step (
		.is_word   (word_ff),
		.dir_right (right_ff),
		.val_in    (val_ff),
		.cy_in     (cy_ff),
		.val_out   (step_val),
		.cy_out    (step_cy)
	);

	// Sequencer; the whole instruction runs with no break-in so memory is atomic
	always_ff @(posedge clk) begin
		if (!nrst) begin
			state_ff <= RTCU_IDLE;
			steps_ff <= 5'd0;
			wait_ff  <= 6'd0;
		end else begin
			case (state_ff)
				RTCU_IDLE: begin
					if (start) begin
						state_ff <= RTCU_RUN;
						steps_ff <= dec_ok ? dec_cnt : 5'd0;
						wait_ff  <= dec_ok ? dec_wait : 6'(RTCU_CLK_VAR_REG - 1); // Undecoded costs a zero-count rotate
					end
				end
				RTCU_RUN: begin
					if (steps_ff != 5'd0) begin
						steps_ff <= steps_ff - 5'd1;
					end else if (wait_ff != 6'd0) begin
						wait_ff <= wait_ff - 6'd1; // Fetch and write-back slots
					end else begin
						state_ff <= RTCU_IDLE; // No extra cycle, so done lands on the counted clock
					end
				end
				default:  state_ff <= RTCU_IDLE;
			endcase
		end
	end

	// Capture operand, then rotate one step per cycle
	always_ff @(posedge clk) begin
		if (!nrst) begin
			val_ff     <= 16'h0000;
			cy_ff      <= 1'b0;
			word_ff    <= 1'b0;
			right_ff   <= 1'b0;
			mem_ff     <= 1'b0;
			cnt_ff     <= 5'd0;
			illegal_ff <= 1'b0;
		end else if (state_ff == RTCU_IDLE && start) begin
			val_ff     <= op_in;
			cy_ff      <= req.carry_flag;
			word_ff    <= dec_word;
			right_ff   <= dec_right;
			mem_ff     <= req.is_mem;
			cnt_ff     <= dec_ok ? dec_cnt : 5'd0;
			illegal_ff <= ~dec_ok;
		end else if (state_ff == RTCU_RUN && steps_ff != 5'd0) begin
			val_ff <= step_val;
			cy_ff  <= step_cy;
		end
	end

	// Overflow: kept at entry, recomputed only for single-step rotates
	always_ff @(posedge clk) begin
		if (!nrst) begin
			of_ff <= 1'b0;
		end else if (state_ff == RTCU_IDLE && start) begin
			of_ff <= req.overflow_flag;
		end
	end

	// Single-step overflow from the rotated ring, ready on the last clock
	always_comb begin
		of_new = of_ff;
		if (cnt_ff == 5'd1) begin
			if (right_ff) begin
				of_new = word_ff ? (val_ff[15] ^ val_ff[14]) : (val_ff[7] ^ val_ff[6]);
			end else begin
				of_new = (word_ff ? val_ff[15] : val_ff[7]) ^ cy_ff;
			end
		end
	end

	// Registered result; zero count returns flags untouched
	always_ff @(posedge clk) begin
		if (!nrst) begin
			rsp_ff  <= '0;
			done_ff <= 1'b0;
		end else begin
			done_ff <= fin_now;
			if (fin_now) begin
				rsp_ff.result        <= val_ff;
				rsp_ff.carry_flag    <= cy_ff;
				rsp_ff.overflow_flag <= of_new;
				rsp_ff.mem_write     <= mem_ff & ~illegal_ff;
				rsp_ff.illegal       <= illegal_ff;
			end
		end
	end

	assign busy = (state_ff != RTCU_IDLE);
	assign done = done_ff;
	assign rsp  = rsp_ff;

endmodule // rtcu_top

// *** hdl/rtcu_pkg.sv ***
// Package of constants and types for the rotate-through-carry unit
package rtcu_pkg;

	// Opcode bytes and reg-field extensions
	localparam logic [7:0] RTCU_OP_ONE_B = 8'hD0;
	localparam logic [7:0] RTCU_OP_ONE_W = 8'hD1;
	localparam logic [7:0] RTCU_OP_CNT_B = 8'hD2;
	localparam logic [7:0] RTCU_OP_CNT_W = 8'hD3;
	localparam logic [7:0] RTCU_OP_IMM_B = 8'hC0;
	localparam logic [7:0] RTCU_OP_IMM_W = 8'hC1;
	localparam logic [2:0] RTCU_EXT_LEFT  = 3'h2;
	localparam logic [2:0] RTCU_EXT_RIGHT = 3'h3;

	// Count field width
	localparam int RTCU_CNT_BITS = 5;

	// Instruction clocks: totals for single-step forms, bases for variable forms (plus one clock per count)
	localparam int RTCU_CLK_ONE_REG = 2;
	localparam int RTCU_CLK_ONE_MEM = 15;
	localparam int RTCU_CLK_VAR_REG = 5;
	localparam int RTCU_CLK_VAR_MEM = 17;

	// Request from decoder and operand fetch
	typedef struct packed {
		logic [7:0]  opcode;
		logic [2:0]  ext;
		logic        is_mem;
		logic [7:0]  immediate_count_byte;
		logic [7:0]  count_register_low;
		logic [15:0] operand;
		logic        carry_flag;
		logic        overflow_flag;
	} rtcu_req_t;

	// Result to core
	typedef struct packed {
		logic [15:0] result;
		logic        carry_flag;
		logic        overflow_flag;
		logic        mem_write;
		logic        illegal;
	} rtcu_rsp_t;

endpackage

// *** hdl/rtcu_step.sv ***
// One rotate-through-carry step over a 9 or 17 bit ring
`timescale 1ns/1ps
module rtcu_step
	import rtcu_pkg::*;
(
	input  wire logic        is_word,
	input  wire logic        dir_right,
	input  wire logic [15:0] val_in,
	input  wire logic        cy_in,
	output logic      [15:0] val_out,
	output logic             cy_out
);
	// Top bit depends on operand size; upper byte kept zero for bytes
	always_comb begin
		val_out = 16'h0000;
		cy_out  = cy_in;
		if (dir_right) begin
			cy_out = val_in[0];
			if (is_word) begin
				val_out = {cy_in, val_in[15:1]};
			end else begin
				val_out = {8'h00, cy_in, val_in[7:1]};
			end
		end else begin
			if (is_word) begin
				cy_out  = val_in[15];
				val_out = {val_in[14:0], cy_in};
			end else begin
				cy_out  = val_in[7];
				val_out = {8'h00, val_in[6:0], cy_in};
			end
		end
	end
endmodule // rtcu_step

// *** sim/rtcu_asserts.sv ***
// Port checker for the rotate-through-carry unit
`timescale 1ns/1ps
module rtcu_asserts
	import rtcu_pkg::*;
(
	input wire logic      clk,
	input wire logic      nrst,
	input wire logic      start,
	input wire rtcu_req_t req,
	input wire logic      busy,
	input wire logic      done,
	input wire rtcu_rsp_t rsp
);
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	// Request taken with a decodable reg field
	sequence s_take; start && !busy && req.ext[2:1] == 2'h1; endsequence
	one_reg_a: assert property (s_take ##0 req.opcode[7:1] == 7'h68 && !req.is_mem |-> ##3 done)
		else $error("one reg");
	one_mem_a: assert property (s_take ##0 req.opcode[7:1] == 7'h68 && req.is_mem |-> ##16 done && rsp.mem_write)
		else $error("one mem");
	zero_cnt_a: assert property (s_take ##0 req.opcode[7:1] == 7'h69 && req.count_register_low[4:0] == 5'h00
		&& !req.is_mem |-> ##6 done && rsp.carry_flag == $past(req.carry_flag, 6)) else $error("zero cnt");
	zero_imm_a: assert property (s_take ##0 req.opcode[7:1] == 7'h60 && req.immediate_count_byte[4:0] == 5'h00
		&& req.is_mem |-> ##18 done) else $error("zero imm");
	bad_op_a: assert property (start && !busy && req.opcode == 8'h90 |-> ##6 done && rsp.illegal) else $error("bad");
	take_busy_a: assert property (start && !busy |=> busy) else $error("take");
	done_pulse_a: assert property (done |-> !busy ##1 !done) else $error("pulse");
	rsp_hold_a: assert property (!done |-> $stable(rsp)) else $error("hold");
endmodule // rtcu_asserts
bind rtcu_top rtcu_asserts u_chk (.clk(clk), .nrst(nrst), .start(start), .req(req),
	.busy(busy), .done(done), .rsp(rsp));

// *** sim/rtcu_feed.sv ***
// Decoder side model: offers one request and holds it until taken
`timescale 1ns/1ps
module rtcu_feed
	import rtcu_pkg::*;
(
	input wire logic      clk,
	input wire logic      go,
	input wire rtcu_req_t nreq,
	input wire logic      busy,
	output logic          start = 1'b0,
	output rtcu_req_t     req = '0
);
	// Scrambled once taken, so stale lines never pass as fresh
	always @(posedge clk) begin
		if (go) begin
			start <= 1'b1;
			req <= nreq;
		end else if (start && !busy) begin
			start <= 1'b0;
			req <= ~req;
		end
	end
endmodule // rtcu_feed

// *** sim/tb_top.sv ***
// Self-checking bench for the rotate-through-carry unit
`timescale 1ns/1ps
module tb_top
	import rtcu_pkg::*;
;
	logic      clk = 1'b0;
	logic      nrst = 1'b0;
	logic      go = 1'b0;
	logic      start;
	logic      busy;
	logic      done;
	rtcu_req_t nreq = '0;
	rtcu_req_t req;
	rtcu_rsp_t rsp;
	int        errors = 0;
	int        num_checks = 0;
	rtcu_feed fd (.clk(clk), .go(go), .nreq(nreq), .busy(busy), .start(start), .req(req));
	rtcu_top dut (.clk(clk), .nrst(nrst), .start(start), .req(req), .busy(busy), .done(done), .rsp(rsp));
	// Clock, and a watchdog far past the longest run
	initial forever #50 clk = ~clk;
	initial begin
		#2000000;
		errors++;
		tally_and_finish();
	end
	task automatic chk(string nm, logic [19:0] seen, logic [19:0] exp);
		num_checks++;
		if (seen !== exp) begin
			errors++;
			$display("BAD %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic tally_and_finish();
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// Ring model, one step at a time; returns overflow, carry, result
	function automatic logic [17:0] ref_rot(rtcu_req_t r, int n);
		logic [16:0] g;
		logic [15:0] s;
		logic        w;
		logic        c;
		logic        o;
		w = r.opcode[0];
		g = w ? {r.carry_flag, r.operand} : 17'({r.carry_flag, r.operand[7:0]});
		for (int i = 0; i < n; i++)
			g = r.ext[0] ? (w ? {g[0], g[16:1]} : {8'h00, g[0], g[8:1]}) : (w ? {g[15:0], g[16]} : {8'h00, g[7:0], g[8]});
		c = w ? g[16] : g[8];
		s = w ? g[15:0] : {8'h00, g[7:0]};
		o = r.ext[0] ? s[w ? 15 : 7] ^ s[w ? 14 : 6] : s[w ? 15 : 7] ^ c;
		return {n == 1 ? o : r.overflow_flag, c, s};
	endfunction
	// One instruction through the feeder, timed from the taking edge
	task automatic run(rtcu_req_t r);
		int   n;
		int   k;
		logic ok;
		logic one;
		one = r.opcode[7:1] == 7'h68;
		ok = r.ext[2:1] == 2'h1 && (one || r.opcode[7:1] == 7'h69 || r.opcode[7:1] == 7'h60);
		n = one ? 1 : r.opcode[1] ? r.count_register_low[4:0] : r.immediate_count_byte[4:0];
		@(posedge clk);
		nreq <= r;
		go <= 1'b1;
		@(posedge clk);
		go <= 1'b0;
		do @(posedge clk); while (!(start && !busy));
		k = 0;
		do begin
			@(posedge clk);
			#1;
			k++;
		end while (!done && k < 60);
		chk("cycles", 20'(k), 20'(!ok ? RTCU_CLK_VAR_REG : one ? (r.is_mem ? RTCU_CLK_ONE_MEM : RTCU_CLK_ONE_REG)
			: (r.is_mem ? RTCU_CLK_VAR_MEM : RTCU_CLK_VAR_REG) + n));
		chk("rsp", {rsp.illegal, rsp.mem_write, rsp.overflow_flag, rsp.carry_flag, ok ? rsp.result : 16'h0000},
			{!ok, r.is_mem && ok, ok ? ref_rot(r, n) : {r.overflow_flag, r.carry_flag, 16'h0000}});
	endtask
	initial begin
		rtcu_req_t r;
		void'($urandom(32'h755f));
		repeat (5) @(posedge clk);
		nrst <= 1'b1;
		r = {8'hD1, 3'h2, 1'b0, 16'h0000, 16'h4889, 2'h2};
		run(r);
		// Every opcode and direction; first dozen have masked zero counts
		for (int i = 0; i < 96; i++) begin
			r = 46'({$urandom, $urandom});
			r.opcode = (i % 6 < 4 ? 8'hD0 : 8'hC0) | 8'(i % 6 % 4);
			r.ext = (i / 6) % 2 ? 3'h3 : 3'h2;
			r.count_register_low &= i < 12 ? 8'hE0 : 8'hFF;
			r.immediate_count_byte &= i < 12 ? 8'hE0 : 8'hFF;
			if (i < 12) r.is_mem = 1'((i / 2) % 2);  // Register and memory forms of every zero count
			run(r);
		end
		// Undecoded opcode, then undecoded reg field
		r.opcode = 8'h90;
		run(r);
		r.opcode = 8'hD0;
		r.ext = 3'h0;
		run(r);
		tally_and_finish();
	end
endmodule // tb_top
